//--- logic/stm_timer.v
// Purpose: 16-bit standard timer with compare, capture, pwm/single pulse and timer modes
// Assumes: high_speed_clk_en and time_base_clk_en are one-cycle enables in the clk domain
// Notes: all outputs registered; the timer pin is a two-way pin with active-low enable
`include "stm_map.vh"

// Functional notes
// - 16-bit up-counter from selected internal clock or external clock pin.
// - period comparator checks period value against counter bits 15 to 8.
// - compare-A comparator checks all sixteen counter bits.
// - no software write to counter; software clears it only by a module-on rising edge.
// - counter auto-clears on overflow or associated comparator match.
// - pause holds the counter; counting resumes from held value.
// - three-bit clock select picks one of eight counter clock sources.
// - module off stops counter; falling module-on keeps residual value.
// - compare mode: module-on rising edge resets pin to output-control level.
// - control 0 bits 2 to 0 read as zero.
// - two-bit mode field selects compare, capture, pwm, timer mode.
// - compare mode pin action on match A: none, low, high, toggle.
// - compare mode pin changes on match A only, never period match.
// - pwm mode function: force inactive, force active, pwm, single pulse.
// - capture mode trigger: rising, falling, both edges, disabled.
// - requested level equal to initial level gives no visible change.
// - output control sets initial level or pwm active level; not in timer mode.
// - polarity bit inverts pin in compare and pwm modes only.
// - swap bit exchanges period and duty roles in pwm mode.
module stm_timer (
  input wire clk,
  input wire rstn,
  input wire clk_en,
  input wire [`STM_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire high_speed_clk_en,
  input wire time_base_clk_en,
  input wire external_clock_pin,
  input wire timer_pin_in,
  output reg timer_output_pin,
  output reg timer_pin_oe_n
);

  // ************************************************************
  // registers
  // ************************************************************
  reg [7:0] ctrl0;
  reg [7:0] ctrl1;
  reg [15:0] compare_a_value;
  reg [7:0] period_compare_value;
  reg [15:0] count;
  reg [15:0] capture_value;
  reg on_d;
  reg [1:0] ext_sync;
  reg ext_prev;
  reg [1:0] sys_div;
  reg [5:0] h_div;
  reg pin_sync0;
  reg pin_sync1;
  reg pin_prev;
  reg cmp_level;
  reg pulse_done;

  wire counter_pause = ctrl0[`STM_C0_PAUSE];
  wire [2:0] clock_select = ctrl0[`STM_C0_CKSEL_HI:`STM_C0_CKSEL_LO];
  wire module_on = ctrl0[`STM_C0_ON];
  wire [1:0] mode = ctrl1[`STM_C1_MODE_HI:`STM_C1_MODE_LO];
  wire [1:0] output_function = ctrl1[`STM_C1_FUNC_HI:`STM_C1_FUNC_LO];
  wire output_control = ctrl1[`STM_C1_OCTRL];
  wire output_polarity = ctrl1[`STM_C1_POL];
  wire period_duty_swap = ctrl1[`STM_C1_SWAP];
  wire counter_clear_select = ctrl1[`STM_C1_CCLR];

  // mode decode shared by the readback, capture and pin logic
  function mode_is;
    input [1:0] m;
    input [1:0] want;
    begin
      mode_is = (m == want);
    end
  endfunction

  wire is_cmp = mode_is(mode, `STM_MODE_CMP);
  wire is_cap = mode_is(mode, `STM_MODE_CAP);

  function wr_hit;
    input [`STM_ADDR_W-1:0] a;
    input [`STM_ADDR_W-1:0] ofs;
    begin
      wr_hit = wr && (a == ofs);
    end
  endfunction

  // ************************************************************
  // counter clock selection
  // ************************************************************
  // the external pin is synchronised before its edge is looked at
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_sync <= 2'h0;
      ext_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_sync <= {ext_sync[0], external_clock_pin};
      ext_prev <= ext_sync[1];
    end
  end

  // ************************************************************
  // prescalers
  // ************************************************************
  // prescalers run free of module_on, so a restart does not realign their phase
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sys_div <= 2'h0;
      h_div <= 6'h00;
    end
    else if (clk_en)
    begin
      sys_div <= sys_div + 2'h1;
      if (high_speed_clk_en)
        h_div <= h_div + 6'h01;
    end
  end

  wire ext_rise = ext_sync[1] & ~ext_prev;
  wire ext_fall = ~ext_sync[1] & ext_prev;

  reg tick;
  always @*
  begin
    case (clock_select)
      `STM_CK_SYS4: tick = (sys_div == `STM_SYS_DIV);
      `STM_CK_SYS: tick = 1'b1;
      `STM_CK_H16: tick = high_speed_clk_en && (h_div[3:0] == 4'hf);
      `STM_CK_H64: tick = high_speed_clk_en && (h_div == 6'h3f);
      `STM_CK_TBC: tick = time_base_clk_en;
      `STM_CK_H8: tick = high_speed_clk_en && (h_div[2:0] == 3'h7);
      `STM_CK_EXT_R: tick = ext_rise;
      `STM_CK_EXT_F: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end

  // ************************************************************
  // comparators and clear
  // ************************************************************
  wire match_p = (count[15:8] == period_compare_value) && (count[7:0] == 8'hff);
  wire match_a = (count == compare_a_value);
  wire overflow = (count == 16'hffff);
  wire is_pwm = mode_is(mode, `STM_MODE_PWM);
  wire period_zero_p = (period_compare_value == 8'h00);
  // in pwm the swap bit picks the clear; otherwise the clear select bit does
  wire use_a_clear = is_pwm ? period_duty_swap : counter_clear_select;
  // an all-zero compare A would clear at every tick, so it falls back to overflow
  wire cmp_a_zero = (compare_a_value == 16'h0000);
  wire clear_now = use_a_clear ? (cmp_a_zero ? overflow : match_a) :
                   (period_zero_p ? overflow : match_p);
  wire on_rise = module_on & ~on_d;
  wire run = module_on && !counter_pause && tick;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= 16'h0000;
      on_d <= 1'b0;
    end
    else if (clk_en)
    begin
      on_d <= module_on;
      if (on_rise)
        count <= 16'h0000;
      else if (run)
      begin
        if (clear_now)
          count <= 16'h0000;
        else
          count <= count + 16'h0001;
      end
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  // in capture mode the counter pair shows the captured value
  wire [15:0] shown_count = is_cap ? capture_value : count;

  // one decode for every readable offset; unmapped offsets read zero
  function [7:0] read_value;
    input [`STM_ADDR_W-1:0] a;
    begin
      case (a)
        `STM_OFS_CTRL0: read_value = {ctrl0[7:3], 3'h0};
        `STM_OFS_CTRL1: read_value = ctrl1;
        `STM_OFS_CNT_LO: read_value = shown_count[7:0];
        `STM_OFS_CNT_HI: read_value = shown_count[15:8];
        `STM_OFS_CMPA_LO: read_value = compare_a_value[7:0];
        `STM_OFS_CMPA_HI: read_value = compare_a_value[15:8];
        `STM_OFS_PERIOD: read_value = period_compare_value;
        default: read_value = 8'h00;
      endcase
    end
  endfunction

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl0 <= `STM_CTRL0_RST;
      ctrl1 <= `STM_CTRL1_RST;
      compare_a_value <= `STM_CMPA_RST;
      period_compare_value <= `STM_PERIOD_RST;
      rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      // the counter registers have no write path
      if (wr_hit(addr, `STM_OFS_CTRL0))
        ctrl0 <= {wdata[7:3], 3'h0};
      if (wr_hit(addr, `STM_OFS_CTRL1))
        ctrl1 <= wdata;
      if (wr_hit(addr, `STM_OFS_CMPA_LO))
        compare_a_value[7:0] <= wdata;
      if (wr_hit(addr, `STM_OFS_CMPA_HI))
        compare_a_value[15:8] <= wdata;
      if (wr_hit(addr, `STM_OFS_PERIOD))
        period_compare_value <= wdata;
      if (rd)
        rdata <= read_value(addr);
      else
        rdata <= 8'h00;
    end
  end

  // ************************************************************
  // capture input
  // ************************************************************
  // edges come from the second synchroniser stage and its delayed copy only
  wire pin_rise = pin_sync1 & ~pin_prev;
  wire pin_fall = ~pin_sync1 & pin_prev;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_sync0 <= 1'b0;
      pin_sync1 <= 1'b0;
      pin_prev <= 1'b0;
      capture_value <= 16'h0000;
    end
    else if (clk_en)
    begin
      pin_sync0 <= timer_pin_in;
      pin_sync1 <= pin_sync0;
      pin_prev <= pin_sync1;
      if (module_on && is_cap)
      begin
        case (output_function)
          2'h0:
          begin
            if (pin_rise)
              capture_value <= count;
          end
          2'h1:
          begin
            if (pin_fall)
              capture_value <= count;
          end
          2'h2:
          begin
            if (pin_rise || pin_fall)
              capture_value <= count;
          end
          default: capture_value <= capture_value;
        endcase
      end
    end
  end

  // ************************************************************
  // output pin
  // ************************************************************
  // duty compare: swap picks which register sets duty
  wire [15:0] duty_value = period_duty_swap ?
    (period_zero_p ? 16'hffff : {period_compare_value, 8'h00}) : compare_a_value;
  wire [16:0] period_len = period_duty_swap ? {1'b0, compare_a_value} :
    (period_zero_p ? 17'h10000 : {1'b0, period_compare_value, 8'h00});
  wire duty_active = ({1'b0, duty_value} >= period_len) || (count < duty_value);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cmp_level <= 1'b0;
    else if (clk_en)
    begin
      if (on_rise)
        cmp_level <= output_control;
      else if (run && match_a && is_cmp)
      begin
        case (output_function)
          2'h1: cmp_level <= 1'b0;
          2'h2: cmp_level <= 1'b1;
          2'h3: cmp_level <= ~cmp_level;
          default: cmp_level <= cmp_level;
        endcase
      end
    end
  end

  // a single pulse ends at the first counter clear after switch-on
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pulse_done <= 1'b0;
    else if (clk_en)
    begin
      if (on_rise)
        pulse_done <= 1'b0;
      else if (run && is_pwm && clear_now)
        pulse_done <= 1'b1;
    end
  end

  reg raw_level;
  always @*
  begin
    case (output_function)
      2'h0: raw_level = ~output_control;
      2'h1: raw_level = output_control;
      2'h2: raw_level = (module_on && duty_active) ? output_control : ~output_control;
      2'h3: raw_level = (module_on && !pulse_done && duty_active) ?
                        output_control : ~output_control;
      default: raw_level = ~output_control;
    endcase
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_output_pin <= 1'b0;
      timer_pin_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      case (mode)
        `STM_MODE_CMP:
        begin
          timer_output_pin <= cmp_level ^ output_polarity;
          timer_pin_oe_n <= 1'b0;
        end
        `STM_MODE_PWM:
        begin
          timer_output_pin <= raw_level ^ output_polarity;
          timer_pin_oe_n <= 1'b0;
        end
        // capture and timer modes leave the pin free
        default:
        begin
          timer_output_pin <= 1'b0;
          timer_pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

endmodule // stm_timer

//--- logic/stm_map.vh
// Purpose: register offsets, field positions and reset values of the standard timer
// Assumes: byte-wide registers on a plain address/strobe port
// Notes: definitions only
`ifndef STM_MAP_VH
`define STM_MAP_VH
`define STM_ADDR_W 3
`define STM_OFS_CTRL0 3'h0
`define STM_OFS_CTRL1 3'h1
`define STM_OFS_CNT_LO 3'h2
`define STM_OFS_CNT_HI 3'h3
`define STM_OFS_CMPA_LO 3'h4
`define STM_OFS_CMPA_HI 3'h5
`define STM_OFS_PERIOD 3'h6
`define STM_CTRL0_RST 8'h00
`define STM_CTRL1_RST 8'h00
`define STM_CMPA_RST 16'h0000
`define STM_PERIOD_RST 8'h00
`define STM_C0_PAUSE 7
`define STM_C0_CKSEL_HI 6
`define STM_C0_CKSEL_LO 4
`define STM_C0_ON 3
`define STM_C1_MODE_HI 7
`define STM_C1_MODE_LO 6
`define STM_C1_FUNC_HI 5
`define STM_C1_FUNC_LO 4
`define STM_C1_OCTRL 3
`define STM_C1_POL 2
`define STM_C1_SWAP 1
`define STM_C1_CCLR 0
`define STM_MODE_CMP 2'h0
`define STM_MODE_CAP 2'h1
`define STM_MODE_PWM 2'h2
`define STM_MODE_TMR 2'h3
`define STM_CK_SYS4 3'h0
`define STM_CK_SYS 3'h1
`define STM_CK_H16 3'h2
`define STM_CK_H64 3'h3
`define STM_CK_TBC 3'h4
`define STM_CK_H8 3'h5
`define STM_CK_EXT_R 3'h6
`define STM_CK_EXT_F 3'h7
`define STM_SYS_DIV 2'h3
`endif

//--- testbench/stm_chk.sv
// Purpose: port checker for the standard timer
// Assumes: control registers change only through the register port
// Notes: shadows both control registers from observed writes
module stm_chk (
  input wire clk,
  input wire rstn,
  input wire clk_en,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire timer_output_pin,
  input wire timer_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c0;
  logic [7:0] c1;
  logic [3:0] age;
  wire [1:0] mode = c1[7:6];
  wire [1:0] func = c1[5:4];
  wire lvl = c1[3] ^ c1[2];
  // pin outputs lag a control write by a few cycles, so judge only settled setups
  wire ok = age > 4'h4;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      c0 <= 8'h00;
      c1 <= 8'h00;
      age <= 4'h0;
    end
    else if (clk_en)
    begin
      if (wr && addr == 3'h0) c0 <= wdata;
      if (wr && addr == 3'h1) c1 <= wdata;
      age <= (wr && addr < 3'h2) ? 4'h0 : age + {3'h0, age != 4'hf};
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_c0_low_zero: assert property (
    rd && clk_en && addr == 3'h0 |=> rdata[2:0] == 3'h0) else $error("ctrl0 low bits set");
  a_timer_release: assert property (
    ok && mode == 2'h3 |-> timer_pin_oe_n && !timer_output_pin) else $error("pin held");
  a_capture_release: assert property (
    ok && mode == 2'h1 |-> timer_pin_oe_n) else $error("pin driven in capture");
  a_cmp_drives: assert property (
    ok && mode == 2'h0 |-> !timer_pin_oe_n) else $error("pin not driven");
  a_on_init: assert property (
    $rose(c0[3]) && mode == 2'h0 |-> ##[1:4] timer_output_pin == lvl)
    else $error("no initial level");
  a_func_hold: assert property (
    ok && mode == 2'h0 && func == 2'h0 |=> $stable(timer_output_pin)) else $error("pin moved");
  a_pwm_inactive: assert property (
    ok && c0[3] && mode == 2'h2 && func == 2'h0 |-> timer_output_pin == !lvl)
    else $error("not inactive");
  a_pwm_active: assert property (
    ok && c0[3] && mode == 2'h2 && func == 2'h1 |-> timer_output_pin == lvl)
    else $error("not active");
  cover property ($rose(timer_output_pin));
  cover property ($rose(c0[3]) && mode == 2'h0);
  cover property (ok && mode == 2'h2);
endmodule // stm_chk

bind stm_timer stm_chk i_chk (.clk, .rstn, .clk_en, .addr, .wdata, .wr, .rd, .rdata,
  .timer_output_pin, .timer_pin_oe_n);

//--- testbench/stm_far.sv
// Purpose: far side: external clock source and board pin
// Assumes: pulses are slow against the two-stage synchroniser
// Notes: a released pin rests at the pull-up level
module stm_far (
  input wire clk,
  input wire timer_output_pin,
  input wire timer_pin_oe_n,
  output logic external_clock_pin,
  output wire timer_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign timer_pin_in = timer_pin_oe_n ? 1'b1 : timer_output_pin;
  initial external_clock_pin = 1'b0;
  // clock stands low between bursts
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge clk) external_clock_pin <= 1'b1;
      repeat (4) @(posedge clk);
      external_clock_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // stm_far

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the standard timer
// Assumes: counts come from the external clock pin
// Notes: read data and pin changes are matched against queued notes
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic high_speed_clk_en = 1'b0;
  logic time_base_clk_en = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rv;
  logic [7:0] exp_q[$];
  logic pin_q[$];
  wire [7:0] rdata;
  wire external_clock_pin, timer_pin_in, timer_output_pin, timer_pin_oe_n;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  stm_timer i_dut (.clk, .rstn, .clk_en, .addr, .wdata, .wr, .rd, .rdata, .high_speed_clk_en,
    .time_base_clk_en, .external_clock_pin, .timer_pin_in, .timer_output_pin, .timer_pin_oe_n);
  stm_far i_far (.clk, .timer_output_pin, .timer_pin_oe_n, .external_clock_pin, .timer_pin_in);
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", what, e, g);
      err_count++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic cnt(input int n, input logic [7:0] e);
    i_far.pulses(n);
    repeat (6) @(posedge clk);
    rd_reg(3'h2, e);
  endtask
  // ****************
  // watchers
  // ****************
  always @(posedge clk)
  begin
    high_speed_clk_en <= 1'($urandom_range(1));
    time_base_clk_en <= 1'($urandom_range(1));
    rd_q <= rd;
    cyc <= cyc + 1;
    if (rd_q) chk("rdata", exp_q.pop_front(), rdata);
    if (cyc == 20000)
    begin
      err_count++;
      close_out();
    end
  end
  always @(timer_output_pin)
    if (rstn) chk("pin", pin_q.size() > 0 ? 8'(pin_q.pop_front()) : 8'hxx, 8'(timer_output_pin));
  // ****************
  // sequence
  // ****************
  initial
  begin
    rv = 8'($urandom(36));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(3'h0, 8'h00);
    rd_reg(3'h1, 8'h00);
    rd_reg(3'h7, 8'h00);
    for (int a = 4; a < 7; a++)
    begin
      rv = 8'($urandom);
      wr_reg(3'(a), rv);
      rd_reg(3'(a), rv);
    end
    wr_reg(3'h0, 8'hff);
    rd_reg(3'h0, 8'hf8);
    wr_reg(3'h0, 8'h60);
    wr_reg(3'h0, 8'h68);
    cnt(5, 8'h05);
    rd_reg(3'h3, 8'h00);
    wr_reg(3'h0, 8'he8);
    cnt(3, 8'h05);
    wr_reg(3'h0, 8'h68);
    cnt(2, 8'h07);
    wr_reg(3'h0, 8'h78);
    cnt(2, 8'h09);
    wr_reg(3'h0, 8'h70);
    cnt(2, 8'h09);
    wr_reg(3'h2, 8'h55);
    cnt(0, 8'h09);
    wr_reg(3'h0, 8'h78);
    cnt(0, 8'h00);
    wr_reg(3'h4, 8'h03);
    wr_reg(3'h5, 8'h00);
    wr_reg(3'h0, 8'h60);
    wr_reg(3'h1, 8'h39);
    pin_q = '{1'b1, 1'b0};
    wr_reg(3'h0, 8'h68);
    cnt(4, 8'h00);
    wr_reg(3'h0, 8'h60);
    wr_reg(3'h1, 8'h29);
    pin_q.push_back(1'b1);
    wr_reg(3'h0, 8'h68);
    cnt(4, 8'h00);
    wr_reg(3'h0, 8'h60);
    pin_q = '{1'b0, 1'b1};
    wr_reg(3'h1, 8'h1d);
    wr_reg(3'h0, 8'h68);
    cnt(4, 8'h00);
    wr_reg(3'h0, 8'h60);
    pin_q.push_back(1'b0);
    wr_reg(3'h1, 8'hc1);
    wr_reg(3'h0, 8'h68);
    cnt(4, 8'h00);
    wr_reg(3'h0, 8'h60);
    pin_q.push_back(1'b1);
    wr_reg(3'h1, 8'h98);
    wr_reg(3'h0, 8'h68);
    repeat (8) @(posedge clk);
    pin_q.push_back(1'b0);
    wr_reg(3'h0, 8'h60);
    wr_reg(3'h1, 8'h88);
    wr_reg(3'h0, 8'h68);
    repeat (8) @(posedge clk);
    wr_reg(3'h0, 8'h60);
    wr_reg(3'h1, 8'h40);
    wr_reg(3'h0, 8'h68);
    repeat (8) @(posedge clk);
    chk("pin notes left", 8'h00, 8'(pin_q.size()));
    close_out();
  end
endmodule // tb_top
